// File: hdl/rsc_pkg.sv
/*
  package for the reset strap capture block: register map, strap bit
  positions, management mode codes, capture states and the carrier struct.
  assumes a single 250 MHz system clock and an active-low async reset.
*/
// Contract
// - strap 0 high enables serial interface debounce
// - debounce: open-drain data out, else push-pull
// - three-bit strap field selects management mode
// - pull-up is one; strap 1 is mode LSB
// - serial-only mode passes processor frames serially
// - unmanaged: no serial frames, EEPROM boot allowed
// - straps 6..4 give default serial device address
// - strap 4 is device identifier LSB
// - strap 7 high means EEPROM absent
// - strap 9 high enables module detection
// - strap 11 high enables MAC power saving
// - strap 12 high enables timeout internal reset
// - fast port tx enables kept, read back
// - uplink tx enable and error kept, read back
// - after reset straps drive the status outputs
package rsc_pkg;
  // strap field positions
  localparam int STRAP_W        = 16;
  localparam int BIT_DEBOUNCE   = 0;
  localparam int BIT_MODE_LSB   = 1;
  localparam int BIT_ID_LSB     = 4;
  localparam int BIT_EEPROM_ABS = 7;
  localparam int BIT_MOD_DETECT = 9;
  localparam int BIT_PWR_SAVE   = 11;
  localparam int BIT_TMO_RESET  = 12;
  localparam int STATUS_W       = 4;
  localparam int FAST_PORTS     = 2;
  localparam int UPLINK_W       = 2;

  // management interface mode codes
  localparam logic [2:0] MODE_PAR16      = 3'h0;
  localparam logic [2:0] MODE_PAR8       = 3'h1;
  localparam logic [2:0] MODE_SERIAL_MII = 3'h2;
  localparam logic [2:0] MODE_SERIAL     = 3'h3;
  localparam logic [2:0] MODE_UNMANAGED  = 3'h7;

  // register byte offsets
  localparam logic [7:0] OFF_STRAP  = 8'h00;
  localparam logic [7:0] OFF_DECODE = 8'h04;
  localparam logic [7:0] OFF_FAST   = 8'h08;
  localparam logic [7:0] OFF_UPLINK = 8'h0C;
  localparam logic [7:0] OFF_CTRL   = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // decode register layout
  localparam int DEC_MODE_LSB = 0;
  localparam int DEC_ID_LSB   = 4;
  localparam int DEC_FLAG_LSB = 8;

  // control register: bit 0 lets the status pins be driven
  localparam logic [1:0] CTRL_RESET   = 2'h1;
  localparam int         CTRL_STAT_EN = 0;
  localparam int         CTRL_PUSH_PULL = 1;

  // capture state, one-hot
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b10
  } rsc_state_e;

  // decoded power-up configuration
  typedef struct packed {
    logic       debounceEn;
    logic       dataOpenDrain;
    logic [2:0] mgmtMode;
    logic       cpuSerialFrameEn;
    logic       unmanaged;
    logic       eepromBootEn;
    logic [2:0] deviceId;
    logic       eepromAbsent;
    logic       moduleDetectEn;
    logic       powerSaveEn;
    logic       timeoutResetEn;
  } rsc_cfg_s;
endpackage

// File: hdl/rsc_capture_reg.sv
/*
  one group of strap flops: loads the pin levels on a single load pulse and
  holds them. assumes load is raised once, at the first edge after reset.
*/
module rsc_capture_reg #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // pin levels and load strobe
  input  wire logic [W-1:0] pinLevel,
  input  wire logic         load,
  // held value
  output logic      [W-1:0] held
);
  // async reset takes a constant; the pin is sampled only by the clocked load
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      held <= '0;
    end else if (load) begin
      held <= pinLevel;
    end
  end

  // once loaded the value must never move again until the next reset
  logic loaded; // set by the first load
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      loaded <= 1'b0;
    end else if (load) begin
      loaded <= 1'b1;
    end
  end

  property p_hold;
    @(posedge sys_clk) disable iff (!nrst) loaded |=> $stable(held);
  endproperty
  a_hold: assert property (p_hold) else $error("strap capture changed after load");
endmodule

// File: hdl/rsc_top.sv
/*
  reset strap capture: samples the strap pins at reset release, decodes the
  power-up configuration, keeps the user straps, then turns the shared pins
  into status outputs. registers sit behind an APB slave.
  assumes the board pulls every strap pin and the pins are synchronous.
*/
module rsc_top
  import rsc_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  // shared strap / status pins
  input  wire logic [rsc_pkg::STRAP_W-1:0] strapStatusPinsI,
  output logic      [rsc_pkg::STRAP_W-1:0] strapStatusPinsO,
  output logic      [rsc_pkg::STRAP_W-1:0] strapStatusPinsOe,
  // fast port transmit enable pins
  input  wire logic [rsc_pkg::FAST_PORTS-1:0] fastPortTxEnableI,
  input  wire logic [rsc_pkg::FAST_PORTS-1:0] fastPortTxEnableMac,
  output logic      [rsc_pkg::FAST_PORTS-1:0] fastPortTxEnableO,
  output logic      [rsc_pkg::FAST_PORTS-1:0] fastPortTxEnableOe,
  // uplink transmit enable and error pins
  input  wire logic                     uplinkTxEnableI,
  input  wire logic                     uplinkTxErrorI,
  input  wire logic                     uplinkTxEnableMac,
  input  wire logic                     uplinkTxErrorMac,
  output logic                          uplinkTxEnableO,
  output logic                          uplinkTxErrorO,
  output logic                          uplinkTxOe,
  // serial interface data output pin
  input  wire logic                     serialDataOutVal,
  output logic                          serialDataOutO,
  output logic                          serialDataOutOe,
  // status from the rest of the switch
  input  wire logic                     initStarted,
  input  wire logic                     memTestBusy,
  input  wire logic                     initDone,
  input  wire logic                     eepromCsumOk,
  // decoded configuration
  output rsc_pkg::rsc_cfg_s             cfg,
  output logic                          cfgValid,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr
);
  import rsc_pkg::*;

  rsc_state_e                state;      // capture state
  rsc_state_e                next_state; // next capture state
  logic                      load;       // one-cycle capture strobe
  logic [STRAP_W-1:0]        strapCap;   // held strap levels
  logic [FAST_PORTS-1:0]     fastCap;    // held fast port user straps
  logic [UPLINK_W-1:0]       uplinkCap;  // held uplink user straps
  logic [1:0]                ctrl;       // software control
  logic [STATUS_W-1:0]       statusQ;    // registered status bits
  logic                      captured;   // straps are valid
  logic [2:0]                mode;       // raw mode field

  // capture sequence: sample at the first edge after release, then run
  always_comb begin
    case (state)
      ST_SAMPLE: next_state = ST_RUN;
      ST_RUN:    next_state = ST_RUN;
      default:   next_state = ST_SAMPLE;
    endcase
  end

  // state flop; a new reset is the only way back to sampling
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_SAMPLE;
    end else begin
      state <= next_state;
    end
  end

  assign load     = (state == ST_SAMPLE);
  assign captured = (state == ST_RUN);
  assign cfgValid = captured;

  // straps: one capture group per pin set, same load strobe for all
  rsc_capture_reg #(.W(STRAP_W)) u_strap (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pinLevel (strapStatusPinsI),
    .load     (load),
    .held     (strapCap)
  );

  rsc_capture_reg #(.W(FAST_PORTS)) u_fast (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pinLevel (fastPortTxEnableI),
    .load     (load),
    .held     (fastCap)
  );

  rsc_capture_reg #(.W(UPLINK_W)) u_uplink (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pinLevel ({uplinkTxErrorI, uplinkTxEnableI}),
    .load     (load),
    .held     (uplinkCap)
  );

  // decode of the held straps; pull-up reads as one
  assign mode = strapCap[BIT_MODE_LSB +: 3];
  always_comb begin
    cfg                  = '0;
    cfg.debounceEn       = strapCap[BIT_DEBOUNCE];
    cfg.dataOpenDrain    = strapCap[BIT_DEBOUNCE];
    cfg.mgmtMode         = mode;
    cfg.cpuSerialFrameEn = (mode == MODE_SERIAL);
    cfg.unmanaged        = (mode == MODE_UNMANAGED);
    // eeprom boot only without a processor and with the part fitted
    cfg.eepromBootEn     = (mode == MODE_UNMANAGED) && !strapCap[BIT_EEPROM_ABS];
    cfg.deviceId         = strapCap[BIT_ID_LSB +: 3];
    cfg.eepromAbsent     = strapCap[BIT_EEPROM_ABS];
    cfg.moduleDetectEn   = strapCap[BIT_MOD_DETECT];
    cfg.powerSaveEn      = strapCap[BIT_PWR_SAVE];
    cfg.timeoutResetEn   = strapCap[BIT_TMO_RESET];
  end

  // status bits registered so the pins come from flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      statusQ <= '0;
    end else begin
      statusQ <= {eepromCsumOk, initDone, memTestBusy, initStarted};
    end
  end

  // shared pins: inputs while sampling, status outputs afterwards
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strapStatusPinsO  <= '0;
      strapStatusPinsOe <= '0;
    end else begin
      // reserved upper pins are driven low
      strapStatusPinsO  <= {{(STRAP_W-STATUS_W){1'b0}}, statusQ};
      // drive only once sampling is over and software allows it
      strapStatusPinsOe <= {STRAP_W{(next_state == ST_RUN) && ctrl[CTRL_STAT_EN]}};
    end
  end

  // user strap pins hand over to the MACs after capture
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fastPortTxEnableO  <= '0;
      fastPortTxEnableOe <= '0;
      uplinkTxEnableO    <= 1'b0;
      uplinkTxErrorO     <= 1'b0;
      uplinkTxOe         <= 1'b0;
    end else begin
      fastPortTxEnableO  <= fastPortTxEnableMac;
      fastPortTxEnableOe <= {FAST_PORTS{next_state == ST_RUN}};
      uplinkTxEnableO    <= uplinkTxEnableMac;
      uplinkTxErrorO     <= uplinkTxErrorMac;
      uplinkTxOe         <= (next_state == ST_RUN);
    end
  end

  // serial data out driver style follows the debounce strap
  // software may force push-pull for bring-up on boards without a pull-up
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      serialDataOutO  <= 1'b0;
      serialDataOutOe <= 1'b0;
    end else if (next_state != ST_RUN) begin
      serialDataOutO  <= 1'b0;
      serialDataOutOe <= 1'b0;
    end else if (cfg.dataOpenDrain && !ctrl[CTRL_PUSH_PULL]) begin
      // open drain: pull low only, release for a one
      serialDataOutO  <= 1'b0;
      serialDataOutOe <= !serialDataOutVal;
    end else begin
      // totem pole: always driven
      serialDataOutO  <= serialDataOutVal;
      serialDataOutOe <= 1'b1;
    end
  end

  // APB: zero-wait access, read data latched in the setup cycle
  logic       setup;  // setup phase of a transfer
  logic       access; // access phase of a transfer
  logic       hit;    // address decodes to a register
  logic [31:0] rdMux; // read data before the flop
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;

  // address decode; anything else answers with an error
  always_comb begin
    hit   = 1'b1;
    rdMux = '0;
    case (paddr)
      OFF_STRAP:  rdMux[STRAP_W-1:0] = strapCap;
      OFF_DECODE: begin
        rdMux[DEC_MODE_LSB +: 3] = cfg.mgmtMode;
        rdMux[DEC_ID_LSB +: 3]   = cfg.deviceId;
        rdMux[DEC_FLAG_LSB +: 9] = {cfg.eepromBootEn, cfg.unmanaged, cfg.cpuSerialFrameEn,
                                    cfg.timeoutResetEn, cfg.powerSaveEn, cfg.moduleDetectEn,
                                    cfg.eepromAbsent, cfg.dataOpenDrain, cfg.debounceEn};
      end
      OFF_FAST:   rdMux[FAST_PORTS-1:0] = fastCap;
      OFF_UPLINK: rdMux[UPLINK_W-1:0]   = uplinkCap;
      OFF_CTRL:   rdMux[1:0]            = ctrl;
      OFF_STATUS: rdMux[STATUS_W:0]     = {captured, statusQ};
      default:    hit = 1'b0;
    endcase
  end

  // read data and error are flops loaded at the setup edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : rdMux;
      pslverr <= !hit || (paddr[1:0] != 2'h0);
    end
  end

  // control register write at the access edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
    end else if (access && pwrite && (paddr == OFF_CTRL)) begin
      ctrl <= pwdata[1:0];
    end
  end

  // checks
  property p_pins_input_in_sample;
    @(posedge sys_clk) disable iff (!nrst)
      !captured |-> (strapStatusPinsOe == '0) && (fastPortTxEnableOe == '0) && !uplinkTxOe && !serialDataOutOe;
  endproperty
  a_pins_input_in_sample: assert property (p_pins_input_in_sample) else $error("pin driven before capture");

  property p_capture_once;
    @(posedge sys_clk) disable iff (!nrst) load |=> captured [*3];
  endproperty
  a_capture_once: assert property (p_capture_once) else $error("capture not final");

  property p_debounce;
    @(posedge sys_clk) disable iff (!nrst) captured |-> cfg.debounceEn == strapCap[BIT_DEBOUNCE];
  endproperty
  a_debounce: assert property (p_debounce) else $error("debounce not from strap");

  property p_open_drain;
    @(posedge sys_clk) disable iff (!nrst)
      captured && $past(captured) && cfg.debounceEn && !ctrl[CTRL_PUSH_PULL] && $stable(ctrl)
      |-> !serialDataOutO && (serialDataOutOe == !$past(serialDataOutVal));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain output wrong");

  property p_push_pull;
    @(posedge sys_clk) disable iff (!nrst)
      captured && $past(captured) && (!$past(cfg.debounceEn) || $past(ctrl[CTRL_PUSH_PULL]))
      |-> serialDataOutOe && (serialDataOutO == $past(serialDataOutVal));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push pull output wrong");

  property p_mode;
    @(posedge sys_clk) disable iff (!nrst) load |=> cfg.mgmtMode == $past(strapStatusPinsI[3:1]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not from straps 3..1");

  property p_serial_frames;
    @(posedge sys_clk) disable iff (!nrst) cfg.cpuSerialFrameEn == (cfg.mgmtMode == MODE_SERIAL);
  endproperty
  a_serial_frames: assert property (p_serial_frames) else $error("serial frame enable wrong");

  property p_unmanaged;
    @(posedge sys_clk) disable iff (!nrst)
      cfg.unmanaged |-> !cfg.cpuSerialFrameEn && (cfg.eepromBootEn == !cfg.eepromAbsent);
  endproperty
  a_unmanaged: assert property (p_unmanaged) else $error("unmanaged decode wrong");

  property p_device_id;
    @(posedge sys_clk) disable iff (!nrst) load |=> cfg.deviceId == $past(strapStatusPinsI[6:4]);
  endproperty
  a_device_id: assert property (p_device_id) else $error("device id not from straps 6..4");

  property p_flags;
    @(posedge sys_clk) disable iff (!nrst) load |=> cfg.eepromAbsent == $past(strapStatusPinsI[7])
      && cfg.moduleDetectEn == $past(strapStatusPinsI[9]) && cfg.powerSaveEn == $past(strapStatusPinsI[11])
      && cfg.timeoutResetEn == $past(strapStatusPinsI[12]);
  endproperty
  a_flags: assert property (p_flags) else $error("single-bit straps decoded wrong");

  property p_fast_read;
    @(posedge sys_clk) disable iff (!nrst) setup && !pwrite && paddr == OFF_FAST |=> prdata == {30'h0, fastCap};
  endproperty
  a_fast_read: assert property (p_fast_read) else $error("fast user strap read wrong");

  property p_uplink_read;
    @(posedge sys_clk) disable iff (!nrst) setup && !pwrite && paddr == OFF_UPLINK |=> prdata == {30'h0, uplinkCap};
  endproperty
  a_uplink_read: assert property (p_uplink_read) else $error("uplink user strap read wrong");

  property p_status_pins;
    @(posedge sys_clk) disable iff (!nrst)
      captured |-> ##2 strapStatusPinsO == {12'h000, $past(eepromCsumOk, 2), $past(initDone, 2),
                                            $past(memTestBusy, 2), $past(initStarted, 2)};
  endproperty
  a_status_pins: assert property (p_status_pins) else $error("status pins lag wrong");

  // once captured the user strap pins belong to the macs again
  property p_tx_oe;
    @(posedge sys_clk) disable iff (!nrst) captured |-> (fastPortTxEnableOe == '1) && uplinkTxOe;
  endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("user strap pins not handed back");

  property p_status_oe;
    @(posedge sys_clk) disable iff (!nrst)
      captured |-> strapStatusPinsOe == {STRAP_W{$past(ctrl[CTRL_STAT_EN])}};
  endproperty
  a_status_oe: assert property (p_status_oe) else $error("status pin drive not from control");

  // single-bit decode against the pins as they stood at the capture edge
  property p_mode_lsb;
    @(posedge sys_clk) disable iff (!nrst) load |=> cfg.mgmtMode[0] == $past(strapStatusPinsI[BIT_MODE_LSB]);
  endproperty
  a_mode_lsb: assert property (p_mode_lsb) else $error("mode lsb not from strap 1");

  property p_id_lsb;
    @(posedge sys_clk) disable iff (!nrst) load |=> cfg.deviceId[0] == $past(strapStatusPinsI[BIT_ID_LSB]);
  endproperty
  a_id_lsb: assert property (p_id_lsb) else $error("device id lsb not from strap 4");

  property p_module_detect;
    @(posedge sys_clk) disable iff (!nrst) load |=> cfg.moduleDetectEn == $past(strapStatusPinsI[BIT_MOD_DETECT]);
  endproperty
  a_module_detect: assert property (p_module_detect) else $error("module detect not from strap 9");

  property p_power_save;
    @(posedge sys_clk) disable iff (!nrst) load |=> cfg.powerSaveEn == $past(strapStatusPinsI[BIT_PWR_SAVE]);
  endproperty
  a_power_save: assert property (p_power_save) else $error("power saving not from strap 11");

  property p_timeout_reset;
    @(posedge sys_clk) disable iff (!nrst) load |=> cfg.timeoutResetEn == $past(strapStatusPinsI[BIT_TMO_RESET]);
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("timeout reset not from strap 12");
endmodule

// File: dv/rsc_strap_board.sv
/*
  board side of the strap pins: one resistor per shared pin, resolved
  against whatever the device drives. assumes the bench sets pull levels.
*/
module rsc_strap_board (
  // device drive
  input  wire logic [15:0] statO,
  input  wire logic [15:0] statOe,
  input  wire logic [1:0]  fastO,
  input  wire logic [1:0]  fastOe,
  input  wire logic [1:0]  upO,
  input  wire logic        upOe,
  input  wire logic        serO,
  input  wire logic        serOe,
  // resistor levels
  input  wire logic [15:0] statPull,
  input  wire logic [1:0]  fastPull,
  input  wire logic [1:0]  upPull,
  // wire levels
  output logic      [15:0] statLvl,
  output logic      [1:0]  fastLvl,
  output logic      [1:0]  upLvl,
  output logic             serLvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin settles to its resistor: pull-up reads as one
  assign statLvl = (statO & statOe) | (statPull & ~statOe);
  assign fastLvl = (fastO & fastOe) | (fastPull & ~fastOe);
  assign upLvl   = upOe ? upO : upPull;
  // data out has a pull-up, so open drain still idles high
  assign serLvl  = serOe ? serO : 1'b1;
endmodule

// File: dv/tb.sv
/*
  bench for the strap capture block: random straps over repeated resets,
  apb reads of the captured values, pin drive after reset.
  assumes the board model resolves every shared pin.
*/
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nErrors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  logic sysClk, nrst, psel, penable, pwrite, pready, pslverr, cfgValid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] statO, statOe, statPull, statLvl;
  logic [1:0] fastO, fastOe, fastPull, fastLvl, fastMac, upPull, upLvl, upMac, upO;
  logic upOe, serVal, serO, serOe, serLvl;
  logic [3:0] stat;
  rsc_cfg_s cfg;
  int nErrors, nTests, cyc;
  // mode codes that must each be seen once
  logic [2:0] modes [5] = '{MODE_PAR16, MODE_PAR8, MODE_SERIAL_MII, MODE_SERIAL, MODE_UNMANAGED};

  rsc_top u_rsc_top (.sys_clk(sysClk), .nrst(nrst), .strapStatusPinsI(statLvl),
    .strapStatusPinsO(statO), .strapStatusPinsOe(statOe), .fastPortTxEnableI(fastLvl),
    .fastPortTxEnableMac(fastMac), .fastPortTxEnableO(fastO), .fastPortTxEnableOe(fastOe),
    .uplinkTxEnableI(upLvl[0]), .uplinkTxErrorI(upLvl[1]), .uplinkTxEnableMac(upMac[0]),
    .uplinkTxErrorMac(upMac[1]), .uplinkTxEnableO(upO[0]), .uplinkTxErrorO(upO[1]),
    .uplinkTxOe(upOe), .serialDataOutVal(serVal), .serialDataOutO(serO),
    .serialDataOutOe(serOe), .initStarted(stat[0]), .memTestBusy(stat[1]),
    .initDone(stat[2]), .eepromCsumOk(stat[3]), .cfg(cfg), .cfgValid(cfgValid),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rsc_strap_board u_rsc_strap_board (.statO(statO), .statOe(statOe), .fastO(fastO),
    .fastOe(fastOe), .upO(upO), .upOe(upOe), .serO(serO), .serOe(serOe),
    .statPull(statPull), .fastPull(fastPull), .upPull(upPull), .statLvl(statLvl),
    .fastLvl(fastLvl), .upLvl(upLvl), .serLvl(serLvl));

  // 250 MHz clock
  initial begin
    sysClk = 1'b0;
    forever #2 sysClk = ~sysClk;
  end

  // expected decode of a captured strap word
  function automatic rsc_cfg_s expCfg(logic [15:0] s);
    rsc_cfg_s c;
    c.debounceEn       = s[0];
    c.dataOpenDrain    = s[0];
    c.mgmtMode         = s[3:1];
    c.cpuSerialFrameEn = (s[3:1] == 3'h3);
    c.unmanaged        = (s[3:1] == 3'h7);
    c.eepromBootEn     = c.unmanaged & ~s[7];
    c.deviceId         = s[6:4];
    c.eepromAbsent     = s[7];
    c.moduleDetectEn   = s[9];
    c.powerSaveEn      = s[11];
    c.timeoutResetEn   = s[12];
    return c;
  endfunction

  // decode register image of the same word
  function automatic logic [31:0] expDec(rsc_cfg_s c);
    return {15'h0, c.eepromBootEn, c.unmanaged, c.cpuSerialFrameEn, c.timeoutResetEn,
      c.powerSaveEn, c.moduleDetectEn, c.eepromAbsent, c.dataOpenDrain, c.debounceEn,
      1'b0, c.deviceId, 1'b0, c.mgmtMode};
  endfunction

  task automatic end_of_test;
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a hang is cut short here
  always @(posedge sysClk) begin
    cyc++;
    if (cyc == 20000) begin
      nErrors++;
      end_of_test;
    end
  end

  // one apb transfer; entered right after a rising edge, leaves one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sysClk);
    penable <= 1'b1;
    // no wait count assumed: only the bench timeout ends a hang
    do begin
      @(posedge sysClk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sysClk);
  endtask

  task automatic chkRd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("rdata", x, r)
    `CHK("slverr", xe, e)
  endtask

  initial begin
    logic [15:0] s;
    logic [1:0] ctrl;
    logic [31:0] r;
    logic e;
    {nrst, psel, penable, pwrite, paddr, pwdata, serVal, stat} = '0;
    {statPull, fastPull, upPull, fastMac, upMac} = '0;
    nErrors = 0;
    nTests = 0;
    cyc = 0;
    void'($urandom(80991));
    for (int i = 0; i < 10; i++) begin
      // board levels; manufacturing straps kept at their fixed levels
      s = 16'($urandom);
      s[3:1] = (i < 5) ? modes[i] : 3'($urandom);
      s[8] = 1'b1;
      s[10] = 1'b0;
      s[15:13] = 3'h7;
      @(posedge sysClk);
      nrst     <= 1'b0;
      statPull <= s;
      fastPull <= 2'($urandom);
      upPull   <= 2'($urandom);
      repeat (3) @(posedge sysClk);
      `CHK("pin drive in reset", 21'h0, {statOe, fastOe, upOe, serOe, cfgValid})
      nrst <= 1'b1;
      @(posedge sysClk);
      #1;
      `CHK("cfg", {1'b1, expCfg(s)}, {cfgValid, cfg})
      @(posedge sysClk);
      chkRd(OFF_STRAP, {16'h0, s}, 1'b0);
      chkRd(OFF_DECODE, expDec(expCfg(s)), 1'b0);
      chkRd(OFF_FAST, {30'h0, fastPull}, 1'b0);
      chkRd(OFF_UPLINK, {30'h0, upPull}, 1'b0);
      chkRd(OFF_CTRL, 32'h1, 1'b0);
      chkRd(8'h18, 32'h0, 1'b1);
      chkRd(8'h02, 32'h0, 1'b1);
      // status pins after reset, mac values through the tx pins
      stat    <= 4'($urandom);
      fastMac <= 2'($urandom);
      upMac   <= 2'($urandom);
      repeat (3) @(posedge sysClk);
      #1;
      `CHK("status pins", {12'h0, stat, 16'hFFFF}, {statLvl, statOe})
      `CHK("tx pins", {fastMac, upMac, 3'h7}, {fastO, upO, fastOe, upOe})
      `CHK("tx levels", {fastMac, upMac}, {fastLvl, upLvl})
      // release the pins, move the resistors: captured values must not move
      @(posedge sysClk);
      chkRd(OFF_STATUS, {27'h0, 1'b1, stat}, 1'b0);
      ctrl = 2'($urandom) & 2'h2;
      apb(1'b1, OFF_CTRL, {30'h0, ctrl}, r, e);
      apb(1'b1, OFF_STRAP, 32'hFFFF, r, e);
      `CHK("ro write err", 1'b0, e)
      statPull <= ~s;
      fastPull <= ~fastPull;
      repeat (2) @(posedge sysClk);
      chkRd(OFF_STRAP, {16'h0, s}, 1'b0);
      `CHK("held cfg", expCfg(s), cfg)
      `CHK("released pins", 16'h0, statOe)
      // serial data out driver type follows the debounce strap
      for (int k = 0; k < 2; k++) begin
        serVal <= k[0];
        @(posedge sysClk);
        #1;
        if (s[0] && !ctrl[1]) begin
          `CHK("open drain", {1'b0, ~k[0], k[0]}, {serO, serOe, serLvl})
        end else begin
          `CHK("push pull", {k[0], 1'b1, k[0]}, {serO, serOe, serLvl})
        end
        @(posedge sysClk);
      end
    end
    end_of_test;
  end
endmodule
